// ---- rtl/pix_pkg.sv ----
// Summary of operation
// - Manual analog gain accepts 0 to 680 steps; a variant limits it to 670.
// - Writing gain never changes the black-level offset value.
// - Black level spans zero to plus sixteen gray values at 8-bit depth; the absolute register input abs_offset_i is applied unclamped.
// - Black level resolves in steps of 1/64 LSB at 8-bit depth.
// - Black-level control sits in the feature register at offset 800h.
// - Bit 0 reads one; bit 1 selects the absolute register over the value field.
// - Writing one to bit 5 starts one-push; reads one while busy.
// - Bit 6 switches the offset on or off and reads back its state.
// - Bit 7 selects manual or automatic and reads back the active mode.
// - Value field writes are ignored in automatic or off state.
// - Horizontal mirror reverses pixel order within each line.
// - Mirror pivots on the field-of-view centre and combines with other functions.
// - Raw colour order is R-G-G-B unmirrored and G-R-B-G mirrored.
// - Shading multiplies each pixel by 1 to 2 in 1/256 steps.
// - Shading runs on full horizontal resolution; horizontal binning comes after.
// - Vertical binning, sub-sampling and mirror come before shading.
// - Shading in scalable full-resolution 8-bit mode only up to the 400 Mbit/s tier.
// - Shading data may be generated internally or downloaded.
// - A generated reference can be read back by the host or kept inside.
// - Generation averages frames, finds the brightest pixel, computes each factor; with gen_frames_log2_i at 0 the peak search is skipped.
package pix_pkg;

    // ----------------
    // Register map and field layout
    // ----------------
    localparam logic [31:0] BLACK_LEVEL_FEATURE_CONTROL_ADDR = 32'hf0f00800;
    localparam int          PRESENCE_BIT   = 0;
    localparam int          ABS_BIT        = 1;
    localparam int          ONE_PUSH_BIT   = 5;
    localparam int          ON_OFF_BIT     = 6;
    localparam int          AUTO_BIT       = 7;
    localparam int          VALUE_LSB      = 0;
    localparam int          VALUE_W        = 12;
    localparam logic [11:0] OFFSET_MAX     = 12'h400;   // 16 gray values * 64 steps.
    localparam logic [11:0] OFFSET_RESET   = 12'h000;
    localparam logic        ON_RESET       = 1'b1;
    localparam logic        AUTO_RESET     = 1'b0;
    localparam logic        ABS_RESET      = 1'b0;
    localparam logic [9:0]  GAIN_MAX       = 10'h2a8;   // 680 steps.
    localparam logic [9:0]  GAIN_MAX_SMALL = 10'h29e;   // 670 steps.
    localparam logic [9:0]  GAIN_RESET     = 10'h000;
    localparam int          OFFSET_FRAC    = 6;         // 1/64 LSB at 8 bit.
    localparam int          SHADE_FRAC     = 8;         // 1/256 multiplier step.
    localparam int          ONE_PUSH_CYCLES = 16;

    // ----------------
    // Carriers and enumerations
    // ----------------
    typedef struct packed {
        logic [7:0] data;
        logic       sol;
        logic       eol;
        logic       sof;
    } pixel_t;

    typedef enum logic [1:0] {
        BAYER_RGGB,
        BAYER_GRBG
    } bayer_t;

    typedef enum {
        GEN_IDLE,
        GEN_ACCUM,
        GEN_FACTOR
    } gen_state_t;

endpackage : pix_pkg

// ---- rtl/skid_buffer.sv ----
`timescale 1ns/10ps
module skid_buffer
    import pix_pkg::*;
(
    input  wire logic   clock_i,
    input  wire logic   rst_i,
    input  wire logic   ce_i,
    input  wire logic   in_valid_i,
    output logic        in_ready_o,
    input  wire pixel_t in_data_i,
    output logic        out_valid_o,
    input  wire logic   out_ready_i,
    output pixel_t      out_data_o
);

    // ----------------
    // Two-entry storage
    // ----------------
    pixel_t     mem_q [2];
    logic       wr_q;
    logic       rd_q;
    logic [1:0] cnt_q;
    logic       push;
    logic       pop;

    // Handshakes are combinational; a full buffer stalls the upstream stage.
    assign in_ready_o  = (cnt_q != 2'd2);
    assign out_valid_o = (cnt_q != 2'd0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = ce_i && in_valid_i && in_ready_o;
    assign pop         = ce_i && out_valid_o && out_ready_i;

    // Pointers and occupancy count.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Data storage needs no reset; valid flags guard it.
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

endmodule : skid_buffer

// ---- rtl/pixel_offset_mirror_shading.sv ----
`timescale 1ns/10ps
module pixel_offset_mirror_shading
    import pix_pkg::*;
#(
    parameter int          LINE_MAX  = 64,
    parameter int          PIX_W     = $clog2(LINE_MAX),
    parameter int          FRAMES_W  = 3,
    parameter logic [9:0]  GAIN_LIMIT = GAIN_MAX
) (
    input  wire logic          clock_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    // Feature register access.
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    input  wire logic [31:0]   reg_addr_i,
    input  wire logic [31:0]   reg_wdata_i,
    output logic [31:0]        reg_rdata_o,
    // Loose controls.
    input  wire logic          gain_wr_i,
    input  wire logic [9:0]    gain_i,
    output logic [9:0]         gain_o,
    input  wire logic [11:0]   abs_offset_i,
    input  wire logic          mirror_en_i,
    input  wire logic          color_raw_i,
    output bayer_t             bayer_o,
    input  wire logic          shade_en_i,
    input  wire logic          full_res_mode_i,
    input  wire logic          bus_above_s400_i,
    output logic               shade_active_o,
    input  wire logic          gen_start_i,
    input  wire logic [FRAMES_W-1:0] gen_frames_log2_i,
    output logic               gen_busy_o,
    input  wire logic          coef_wr_i,
    input  wire logic [PIX_W-1:0] coef_addr_i,
    input  wire logic [7:0]    coef_wdata_i,
    output logic [7:0]         coef_rdata_o,
    // Pixel stream in, full horizontal resolution.
    input  wire logic          pix_valid_i,
    output logic               pix_ready_o,
    input  wire pixel_t        pix_i,
    // Pixel stream out toward the formatter.
    output logic               out_valid_o,
    input  wire logic          out_ready_i,
    output pixel_t             out_o
);

    // ----------------
    // Feature register state
    // ----------------
    logic        abs_q;
    logic        on_q;
    logic        auto_q;
    logic        push_busy_q;
    logic [4:0]  push_cnt_q;
    logic [11:0] value_q;
    logic [9:0]  gain_q;
    logic        hit;
    logic [11:0] wvalue;

    assign hit    = (reg_addr_i == BLACK_LEVEL_FEATURE_CONTROL_ADDR);
    assign wvalue = (reg_wdata_i[VALUE_LSB +: VALUE_W] > OFFSET_MAX) ? OFFSET_MAX
                                                                    : reg_wdata_i[VALUE_LSB +: VALUE_W];

    // Control bits; flag n sits at bit 31 - n, clear of the value field.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            abs_q  <= ABS_RESET;
            on_q   <= ON_RESET;
            auto_q <= AUTO_RESET;
        end else if (ce_i && reg_wr_i && hit) begin
            abs_q  <= reg_wdata_i[31 - ABS_BIT];
            on_q   <= reg_wdata_i[31 - ON_OFF_BIT];
            auto_q <= reg_wdata_i[31 - AUTO_BIT];
        end
    end

    // Value field; refused in automatic or off state, judged on the stored state.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            value_q <= OFFSET_RESET;
        end else if (ce_i && reg_wr_i && hit && on_q && !auto_q) begin
            value_q <= wvalue;
        end
    end

    // One-push runs a fixed settle time; the start write wins over completion.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            push_busy_q <= 1'b0;
            push_cnt_q  <= 5'd0;
        end else if (ce_i) begin
            if (reg_wr_i && hit && reg_wdata_i[31 - ONE_PUSH_BIT]) begin
                push_busy_q <= 1'b1;
                push_cnt_q  <= 5'(ONE_PUSH_CYCLES);
            end else if (push_busy_q) begin
                push_cnt_q  <= push_cnt_q - 5'd1;
                push_busy_q <= (push_cnt_q != 5'd1);
            end
        end
    end

    // Gain is its own register and never touches the offset.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            gain_q <= GAIN_RESET;
        end else if (ce_i && gain_wr_i) begin
            gain_q <= (gain_i > GAIN_LIMIT) ? GAIN_LIMIT : gain_i;
        end
    end
    assign gain_o = gain_q;

    // Read data is registered; unmapped addresses read zero.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (ce_i && reg_rd_i) begin
            reg_rdata_o <= 32'h0000_0000;
            if (hit) begin
                reg_rdata_o[31 - PRESENCE_BIT]    <= 1'b1;
                reg_rdata_o[31 - ABS_BIT]         <= abs_q;
                reg_rdata_o[31 - ONE_PUSH_BIT]    <= push_busy_q;
                reg_rdata_o[31 - ON_OFF_BIT]      <= on_q;
                reg_rdata_o[31 - AUTO_BIT]        <= auto_q;
                reg_rdata_o[VALUE_LSB +: VALUE_W] <= value_q;
            end
        end
    end

    // ----------------
    // Shared arithmetic
    // ----------------
    // Offset in 1/64 LSB, rounded and saturated at 8 bits.
    function automatic logic [7:0] add_offset(input logic [7:0] p, input logic [11:0] off);
        logic [15:0] s;
        s = {2'b00, p, 6'b0} + {4'b0, off} + 16'(1 << (OFFSET_FRAC - 1));
        return (s[15:14] != 2'b00) ? 8'hff : s[13:6];
    endfunction : add_offset

    // Multiply by 1 + c/256, rounded and saturated.
    function automatic logic [7:0] shade_mul(input logic [7:0] p, input logic [7:0] c);
        logic [17:0] m;
        m = 18'(p) * 18'({1'b1, c}) + 18'(1 << (SHADE_FRAC - 1));
        return (m[17:16] != 2'b00) ? 8'hff : m[15:8];
    endfunction : shade_mul

    // ----------------
    // Mirror line buffer: lines arrive already vertically processed
    // ----------------
    // A line is stored, then replayed forward or reversed; the ping-pong
    // pair lets the next line fill while the previous one drains.
    logic [7:0]       line_q [2][LINE_MAX];
    logic [PIX_W-1:0] len_q [2];
    logic [1:0]       full_q;
    logic             fsel_q;
    logic             dsel_q;
    logic [PIX_W-1:0] wpos_q;
    logic [PIX_W-1:0] rpos_q;
    logic             sof_q [2];
    logic             mir_q [2];
    logic             take;
    logic             emit;
    logic             buf_ready;
    pixel_t           mpix;

    assign pix_ready_o = !full_q[fsel_q];
    assign take        = ce_i && pix_valid_i && pix_ready_o;

    // Fill side.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            fsel_q <= 1'b0;
            wpos_q <= '0;
        end else if (take) begin
            line_q[fsel_q][wpos_q] <= pix_i.data;
            if (pix_i.eol || wpos_q == PIX_W'(LINE_MAX - 1)) begin
                len_q[fsel_q] <= wpos_q;
                mir_q[fsel_q] <= mirror_en_i;
                fsel_q        <= ~fsel_q;
                wpos_q        <= '0;
            end else begin
                wpos_q <= wpos_q + 1'b1;
            end
            if (pix_i.sol) begin
                sof_q[fsel_q] <= pix_i.sof;
            end
        end
    end

    // Drain side reads left-to-right or right-to-left around the line centre.
    always_comb begin
        mpix.sol  = (rpos_q == '0);
        mpix.eol  = (rpos_q == len_q[dsel_q]);
        mpix.sof  = mpix.sol && sof_q[dsel_q];
        mpix.data = mir_q[dsel_q] ? line_q[dsel_q][len_q[dsel_q] - rpos_q]
                                  : line_q[dsel_q][rpos_q];
    end

    // ----------------
    // Offset and shading stage, full horizontal resolution
    // ----------------
    logic [7:0]  coef_q [LINE_MAX];
    logic        sh_valid_q;
    pixel_t      sh_q;
    logic        shade_ok;
    logic [11:0] eff_off;

    // Scalable full-resolution 8-bit mode above the 400 Mbit/s tier disables it.
    assign shade_ok       = shade_en_i && !(full_res_mode_i && bus_above_s400_i);
    assign shade_active_o = shade_ok;
    assign eff_off        = !on_q ? 12'h000 : (abs_q ? abs_offset_i : value_q);
    assign emit           = ce_i && full_q[dsel_q] && (!sh_valid_q || buf_ready);

    // Line occupancy; a finished fill and a finished drain may meet.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            full_q <= 2'b00;
            dsel_q <= 1'b0;
            rpos_q <= '0;
        end else begin
            if (take && (pix_i.eol || wpos_q == PIX_W'(LINE_MAX - 1))) begin
                full_q[fsel_q] <= 1'b1;
            end
            if (emit) begin
                if (mpix.eol) begin
                    full_q[dsel_q] <= 1'b0;
                    dsel_q         <= ~dsel_q;
                    rpos_q         <= '0;
                end else begin
                    rpos_q <= rpos_q + 1'b1;
                end
            end
        end
    end

    // Shading after mirror, before any horizontal decimation downstream.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sh_valid_q <= 1'b0;
            sh_q       <= '0;
        end else if (ce_i) begin
            if (emit) begin
                sh_valid_q <= 1'b1;
                sh_q       <= mpix;
                sh_q.data  <= shade_ok ? shade_mul(add_offset(mpix.data, eff_off), coef_q[rpos_q])
                                       : add_offset(mpix.data, eff_off);
            end else if (buf_ready) begin
                sh_valid_q <= 1'b0;
            end
        end
    end

    // ----------------
    // Coefficient generation: average, find brightest, derive factors
    // ----------------
    gen_state_t       gen_q;
    logic [15:0]      acc_q [LINE_MAX];
    logic [7:0]       peak_q;
    logic [FRAMES_W+2:0] frm_q;
    logic [PIX_W-1:0] gi_q;
    logic             in_frame_q;
    logic [7:0]       mean;

    assign mean       = 8'(acc_q[gi_q] >> gen_frames_log2_i);
    assign gen_busy_o = (gen_q != GEN_IDLE);

    // Sequencer counts whole frames seen on the input, then sweeps factors.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            gen_q      <= GEN_IDLE;
            frm_q      <= '0;
            gi_q       <= '0;
            peak_q     <= 8'h00;
            in_frame_q <= 1'b0;
        end else if (ce_i) begin
            case (gen_q)
                GEN_IDLE: begin
                    if (gen_start_i) begin
                        gen_q      <= GEN_ACCUM;
                        frm_q      <= '0;
                        in_frame_q <= 1'b0;
                        for (int i = 0; i < LINE_MAX; i++) begin
                            acc_q[i] <= 16'h0000;
                        end
                    end
                end
                GEN_ACCUM: begin
                    if (take && pix_i.sof) begin
                        if (in_frame_q) begin
                            frm_q <= frm_q + 1'b1;
                        end
                        in_frame_q <= 1'b1;
                        if (in_frame_q && frm_q + 1'b1 == (FRAMES_W + 3)'(1 << gen_frames_log2_i)) begin
                            gen_q  <= GEN_FACTOR;
                            gi_q   <= '0;
                            peak_q <= 8'h00;
                        end
                    end
                    if (take && (in_frame_q || pix_i.sof)) begin
                        acc_q[wpos_q] <= acc_q[wpos_q] + 16'(pix_i.data);
                    end
                end
                GEN_FACTOR: begin
                    // First pass finds the peak; second pass writes the factors. With gen_frames_log2_i at 0 only the write pass runs, against a zero peak.
                    if (!frm_q[0]) begin
                        if (mean > peak_q) begin
                            peak_q <= mean;
                        end
                    end
                    if (gi_q == PIX_W'(LINE_MAX - 1)) begin
                        gi_q  <= '0;
                        frm_q <= frm_q + 1'b1;
                        if (frm_q[0]) begin
                            gen_q <= GEN_IDLE;
                        end
                    end else begin
                        gi_q <= gi_q + 1'b1;
                    end
                end
                default: gen_q <= GEN_IDLE;
            endcase
        end
    end

    // Factors are held inside and can be read back or downloaded by the host.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < LINE_MAX; i++) begin
                coef_q[i] <= 8'h00;
            end
        end else if (ce_i) begin
            if (gen_q == GEN_FACTOR && frm_q[0]) begin
                // Factor = peak/mean - 1 in 1/256; the peak pixel keeps zero.
                coef_q[gi_q] <= (mean == 8'h00 || (16'(peak_q) << 8) / 16'(mean) >= 16'h0200) ? 8'hff
                              : 8'(((16'(peak_q) << 8) / 16'(mean)) - 16'h0100);
            end else if (coef_wr_i && !gen_busy_o) begin
                coef_q[coef_addr_i] <= coef_wdata_i;
            end
        end
    end

    // Registered read-back of the reference.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            coef_rdata_o <= 8'h00;
        end else if (ce_i) begin
            coef_rdata_o <= coef_q[coef_addr_i];
        end
    end

    // Bayer order reported for raw colour output.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bayer_o <= BAYER_RGGB;
        end else if (ce_i) begin
            bayer_o <= (color_raw_i && mirror_en_i) ? BAYER_GRBG : BAYER_RGGB;
        end
    end

    // ----------------
    // Output buffer absorbs receiver stalls without losing a pixel
    // ----------------
    skid_buffer u_out_buf (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (sh_valid_q),
        .in_ready_o  (buf_ready),
        .in_data_i   (sh_q),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (out_o)
    );

endmodule : pixel_offset_mirror_shading

// ---- dv/pixel_offset_mirror_shading_sva.sv ----
`timescale 1ns/10ps
module pixel_offset_mirror_shading_sva
    import pix_pkg::*;
#(
    parameter logic [9:0] GAIN_LIMIT = GAIN_MAX
) (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        gain_wr_i,
    input wire logic [9:0]  gain_i,
    input wire logic [9:0]  gain_o,
    input wire logic        mirror_en_i,
    input wire logic        color_raw_i,
    input wire bayer_t      bayer_o,
    input wire logic        shade_en_i,
    input wire logic        full_res_mode_i,
    input wire logic        bus_above_s400_i,
    input wire logic        shade_active_o,
    input wire logic        out_valid_o,
    input wire logic        out_ready_i,
    input wire pixel_t      out_o
);
    // ----------------
    // Properties
    // ----------------
    // Flags use the big-endian bit numbering of the feature register.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_unmapped; ce_i && reg_rd_i && reg_addr_i != BLACK_LEVEL_FEATURE_CONTROL_ADDR |=> reg_rdata_o == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read returned nonzero data.");
    property p_presence; ce_i && reg_rd_i && reg_addr_i == BLACK_LEVEL_FEATURE_CONTROL_ADDR |=> reg_rdata_o[31 - PRESENCE_BIT]; endproperty
    a_presence: assert property (p_presence) else $error("Presence flag read as zero.");
    property p_rd_stands; !(ce_i && reg_rd_i) |=> $stable(reg_rdata_o); endproperty
    a_rd_stands: assert property (p_rd_stands) else $error("Read data changed without a read.");
    property p_gain; ce_i && gain_wr_i |=> gain_o == ($past(gain_i) > GAIN_LIMIT ? GAIN_LIMIT : $past(gain_i)); endproperty
    a_gain: assert property (p_gain) else $error("Gain not taken or not clamped.");
    property p_gain_max; gain_o <= GAIN_LIMIT; endproperty
    a_gain_max: assert property (p_gain_max) else $error("Gain above its limit.");
    property p_bayer; ce_i && color_raw_i && $past(ce_i) && $stable(mirror_en_i) |=> bayer_o == ($past(mirror_en_i) ? BAYER_GRBG : BAYER_RGGB); endproperty
    a_bayer: assert property (p_bayer) else $error("Colour order does not follow mirror.");
    property p_shade_gate; shade_active_o |-> shade_en_i && !(full_res_mode_i && bus_above_s400_i); endproperty
    a_shade_gate: assert property (p_shade_gate) else $error("Shading active where not allowed.");
    property p_out_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o); endproperty
    a_out_hold: assert property (p_out_hold) else $error("Output word lost during stall.");
    c_stall: cover property (out_valid_o && !out_ready_i);
    c_grbg: cover property (bayer_o == BAYER_GRBG);
    c_shade: cover property (shade_active_o && out_valid_o);
endmodule : pixel_offset_mirror_shading_sva
bind pixel_offset_mirror_shading pixel_offset_mirror_shading_sva #(.GAIN_LIMIT(GAIN_LIMIT)) u_sva (.*);

// ---- dv/pixel_stream_partner.sv ----
`timescale 1ns/10ps
module pixel_stream_partner
    import pix_pkg::*;
(
    input  wire logic   clock_i,
    input  wire logic   slow_i,
    input  wire logic   pix_ready_i,
    output logic        pix_valid_o,
    output pixel_t      pix_o,
    input  wire logic   out_valid_i,
    input  wire pixel_t out_i,
    output logic        out_ready_o
);
    logic [7:0] got[$];
    initial begin
        pix_valid_o = 1'b0;
        pix_o = '0;
        out_ready_o = 1'b1;
    end
    // A slow receiver drops ready every other cycle, so the buffer must hold words.
    always @(negedge clock_i) out_ready_o <= slow_i ? ~out_ready_o : 1'b1;
    always @(posedge clock_i) if (out_valid_i && out_ready_o) got.push_back(out_i.data);
    // A pixel is held until the block takes it; bounded so a dead ready cannot hang.
    task automatic send(input logic [7:0] d, input logic sl, input logic el, input logic sf, output logic tk);
        int i;
        @(negedge clock_i);
        pix_valid_o = 1'b1;
        pix_o = '{data: d, sol: sl, eol: el, sof: sf};
        tk = 1'b0;
        for (i = 0; i < 200 && !tk; i++) begin
            @(posedge clock_i);
            tk = pix_ready_i;
        end
    endtask : send
    // The released bus shows inverted data rather than a stale copy.
    task automatic idle();
        @(negedge clock_i);
        pix_valid_o = 1'b0;
        pix_o = ~pix_o;
    endtask : idle
endmodule : pixel_stream_partner

// ---- dv/pixel_offset_mirror_shading_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module pixel_offset_mirror_shading_tb_top;
    import pix_pkg::*;
    localparam int N = 8;
    localparam logic [31:0] A = BLACK_LEVEL_FEATURE_CONTROL_ADDR;
    logic clock_i = 0, rst_i = 1, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, gain_wr_i = 0, gen_start_i = 0, tk, slow = 0;
    logic [31:0] reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o, r;
    logic [9:0] gain_i = '0, gain_o;
    logic [11:0] abs_offset_i = '0;
    logic [2:0] gen_frames_log2_i = '0, coef_addr_i = '0;
    logic mirror_en_i = 0, color_raw_i = 1, shade_en_i = 0, full_res_mode_i = 0, bus_above_s400_i = 0, coef_wr_i = 0;
    logic shade_active_o, gen_busy_o, pix_valid_i, pix_ready_o, out_valid_o, out_ready_i;
    logic [7:0] coef_wdata_i = '0, coef_rdata_o, d[N], e[N];
    bayer_t bayer_o;
    pixel_t pix_i, out_o;
    int miscompares = 0, check_count = 0;
    always #2.5 clock_i = ~clock_i;
    pixel_offset_mirror_shading #(.LINE_MAX(N)) uut (.*);
    pixel_stream_partner prt (.clock_i(clock_i), .slow_i(slow), .pix_ready_i(pix_ready_o), .pix_valid_o(pix_valid_i),
        .pix_o(pix_i), .out_valid_i(out_valid_o), .out_i(out_o), .out_ready_o(out_ready_i));
    // ----------------
    // Helpers
    // ----------------
    // Flag n of the register sits at bit 31-n; the value field is the low 12 bits.
    function automatic logic [31:0] fb(input int n);
        fb = 32'h1 << (31 - n);
    endfunction : fb
    function automatic logic [31:0] ctl(input logic on, input logic au, input logic [11:0] v);
        ctl = (on ? fb(ON_OFF_BIT) : '0) | (au ? fb(AUTO_BIT) : '0) | {20'h0, v};
    endfunction : ctl
    task automatic wr(input logic [31:0] a, input logic [31:0] w);
        @(negedge clock_i); reg_wr_i = 1; reg_addr_i = a; reg_wdata_i = w;
        @(negedge clock_i); reg_wr_i = 0;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(negedge clock_i); reg_rd_i = 1; reg_addr_i = a;
        @(negedge clock_i); reg_rd_i = 0; r = reg_rdata_o;
    endtask : rd
    // Sends one line, waits for it to come back and compares it word by word.
    task automatic line_chk();
        prt.got.delete();
        for (int i = 0; i < N; i++) begin
            prt.send(d[i], i == 0, i == N - 1, i == 0, tk);
            if (!tk) begin miscompares++; results(); end
        end
        prt.idle();
        for (int i = 0; i < 400 && prt.got.size() < N; i++) @(negedge clock_i);
        if (prt.got.size() < N) begin miscompares++; results(); end
        for (int i = 0; i < N; i++) `CHK(prt.got[i], e[i])
    endtask : line_chk
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_reset();
        rd(A); `CHK(r, fb(PRESENCE_BIT) | fb(ON_OFF_BIT))
        rd(A + 32'h4); `CHK(r, 32'h0)
        `CHK(gain_o, GAIN_RESET)
        $display("test reset done");
    endtask : t_reset
    task automatic t_value();
        wr(A, ctl(1, 0, 12'h010)); rd(A); `CHK(r[11:0], 12'h010)
        wr(A, ctl(1, 1, 12'h020)); rd(A); `CHK(r[31 - AUTO_BIT], 1'b1)
        `CHK(r[11:0], 12'h020)
        wr(A, ctl(0, 0, 12'h030)); rd(A); `CHK(r[31 - ON_OFF_BIT], 1'b0)
        wr(A, ctl(1, 0, 12'h031)); rd(A); `CHK(r[11:0], 12'h020)
        wr(A, ctl(1, 0, 12'h7ff)); rd(A); `CHK(r[11:0], OFFSET_MAX)
        @(negedge clock_i); gain_wr_i = 1; gain_i = 10'h2bc;
        @(negedge clock_i); gain_wr_i = 0; `CHK(gain_o, GAIN_MAX)
        rd(A); `CHK(r[11:0], OFFSET_MAX)
        $display("test value done");
    endtask : t_value
    task automatic t_push();
        wr(A, ctl(1, 0, 12'h040) | fb(ONE_PUSH_BIT)); rd(A); `CHK(r[31 - ONE_PUSH_BIT], 1'b1)
        repeat (ONE_PUSH_CYCLES + 4) @(negedge clock_i);
        rd(A); `CHK(r[31 - ONE_PUSH_BIT], 1'b0)
        $display("test one-push done");
    endtask : t_push
    // Mirrored line with a one-gray offset (64 steps of 1/64) and a stalling receiver.
    task automatic t_mirror();
        mirror_en_i = 1; slow = 1;
        for (int i = 0; i < N; i++) begin d[i] = 8'h10 + 8'(i); e[N - 1 - i] = d[i] + 8'h01; end
        line_chk();
        `CHK(bayer_o, BAYER_GRBG)
        mirror_en_i = 0; slow = 0;
        $display("test mirror done");
    endtask : t_mirror
    // Factors 1+32i/256 loaded with mirror already final; the last pixel saturates.
    task automatic t_shade();
        wr(A, ctl(1, 0, 12'h000));
        for (int i = 0; i < N; i++) begin
            @(negedge clock_i); coef_wr_i = 1; coef_addr_i = 3'(i); coef_wdata_i = 8'(32 * i);
            d[i] = (i == N - 1) ? 8'hc8 : 8'h40; e[i] = (i == N - 1) ? 8'hff : 8'h40 + 8'(8 * i);
        end
        @(negedge clock_i); coef_wr_i = 0; shade_en_i = 1;
        @(negedge clock_i); `CHK(shade_active_o, 1'b1)
        line_chk();
        coef_addr_i = 3'd1;
        @(negedge clock_i); `CHK(coef_rdata_o, 8'h20)
        full_res_mode_i = 1; bus_above_s400_i = 1;
        @(negedge clock_i); `CHK(shade_active_o, 1'b0)
        $display("test shading done");
    endtask : t_shade
    task automatic results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (2) @(negedge clock_i);
        rst_i = 0;
        t_reset(); t_value(); t_push(); t_mirror(); t_shade();
        results();
    end
endmodule : pixel_offset_mirror_shading_tb_top
